/* File: dv/adc_spi_shadowed_register_bank_tb_top.sv */
// self-checking bench for the shadowed register bank
module adc_spi_shadowed_register_bank_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int NR = 17;
   localparam logic [7:0] PID = 8'h3c; // arbitrary identity value
   localparam logic [1:0] GRD = 2'h2;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic sclk, csb, sdio_q, sdio_o, sdio_oe, rd_stb, sdio_w;
   logic lsb = 1'b0;
   logic [7:0] va, vb, vg;
   logic [15:0] rd_val;
   logic [2*NR*8-1:0] active_cfg;
   logic [15:0] exp_q[$];
   int n_mismatch = 0;
   int comparisons = 0;
   int cyc = 0;

   // ****************************************************************
   // clock, pin resolution and instances
   // ****************************************************************
   always #2 mclk = ~mclk;
   assign sdio_w = (sdio_oe === 1'b1) ? sdio_o : sdio_q;

   adcsr_reg_bank #(.PART_ID(PID), .GRADE(GRD), .N_REGS(NR)) uut (
      .mclk(mclk),
      .rst_n(rst_n),
      .sclk(sclk),
      .csb(csb),
      .sdio_i(sdio_w),
      .sdio_o(sdio_o),
      .sdio_oe(sdio_oe),
      .active_cfg(active_cfg)
   );

   adcsr_host host (
      .mclk(mclk),
      .sclk(sclk),
      .csb(csb),
      .sdio_q(sdio_q),
      .sdio_w(sdio_w),
      .rd_stb(rd_stb),
      .rd_val(rd_val)
   );

   task automatic results();
      if (n_mismatch == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] s);
      comparisons++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      host.frame(1'b0, 2'h0, a, {8'h00, d}, lsb);
   endtask

   // two-byte write: first byte in the low half
   task automatic wr2(input logic [12:0] a, input logic [15:0] d);
      host.frame(1'b0, 2'h1, a, d, lsb);
   endtask

   // expectation is queued before the frame goes out
   task automatic rd(input logic [12:0] a, input logic [7:0] e);
      exp_q.push_back({8'h00, e});
      host.frame(1'b1, 2'h0, a, 16'h0000, lsb);
   endtask

   task automatic rd2(input logic [12:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      host.frame(1'b1, 2'h1, a, 16'h0000, lsb);
   endtask

   function automatic logic [7:0] act(input int h, input int i);
      return active_cfg[(h*NR+i)*8 +: 8];
   endfunction

   // read monitor: oldest expectation against each finished read
   always @(posedge mclk)
      if (rd_stb === 1'b1)
         chk("read", exp_q.pop_front(), rd_val);

   // hang guard, well above the ~6200 cycles the sequence needs
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         results();
      end
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      va = 8'($urandom(32'hd3a9));
      repeat (4) @(posedge mclk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      chk("clk_dflt", 8'h01, act(0, 1));
      chk("vref_dflt", 8'hc0, act(1, 16));
      rd(13'h000, 8'h18);
      rd(13'h005, 8'h03);
      wr(13'h001, 8'h00);
      rd(13'h001, PID);
      rd(13'h002, {2'h0, GRD, 4'h0});
      // two-byte frames: msb order steps the address downwards
      wr2(13'h00e, {8'h02, 8'h05});
      rd2(13'h00e, {8'h02, 8'h05});
      // open bits kept zero, only assigned addresses written
      vg = 8'($urandom_range(7, 1));
      wr(13'h00b, vg);
      chk("gbl_held", 8'h00, act(0, 3));
      rd(13'h00b, vg);
      va = 8'($urandom_range(63, 1));
      vb = ~va & 8'h3f;
      wr(13'h005, 8'h01);
      wr(13'h010, va);
      wr(13'h005, 8'h02);
      wr(13'h010, vb);
      rd(13'h010, vb);
      wr(13'h005, 8'h03);
      rd(13'h010, va);
      wr(13'h00d, 8'h05);
      wr(13'h0ff, 8'h00);
      chk("no_xfer", 8'h00, act(0, 8));
      wr(13'h0ff, 8'h01);
      // idle port: the active band must hold still meanwhile
      repeat (12) @(posedge mclk);
      #1;
      chk("gbl_a", vg, act(0, 3));
      chk("gbl_b", vg, act(1, 3));
      chk("loc_a", va, act(0, 8));
      chk("loc_b", vb, act(1, 8));
      chk("both_a", 8'h05, act(0, 5));
      chk("both_b", 8'h05, act(1, 5));
      chk("bist_a", 8'h05, act(0, 6));
      chk("bist_b", 8'h05, act(1, 6));
      rd(13'h0ff, 8'h00);
      wr(13'h005, 8'h00);
      wr(13'h00b, 8'h06);
      rd(13'h00b, 8'h06);
      // order switch, then soft reset sent in the new order
      wr(13'h000, 8'h5a);
      lsb = 1'b1;
      rd(13'h000, 8'h5a);
      rd2(13'h00b, {8'h00, 8'h06});
      wr(13'h000, 8'h7e);
      lsb = 1'b0;
      rd(13'h000, 8'h18);
      rd(13'h005, 8'h03);
      chk("srst_gbl", 8'h00, act(0, 3));
      results();
   end
endmodule

/* File: dv/adcsr_host.sv */
// serial master model that frames one- and two-byte register accesses
module adcsr_host (
   // pacing clock
   input wire logic mclk,
   // serial pins
   output logic sclk,
   output logic csb,
   output logic sdio_q,
   input wire logic sdio_w,
   // completed read
   output logic rd_stb,
   output logic [15:0] rd_val
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle: deselected, shift clock parked low
   initial
   begin
      sclk = 1'b0;
      csb = 1'b1;
      sdio_q = 1'b0;
      rd_stb = 1'b0;
      rd_val = 16'h0000;
   end

   task automatic half(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // one frame, 4 mclk per phase; lsb flips every field's order
   // w is 0 or 1 here: one or two bytes, byte k in dat[8k +: 8]
   task automatic frame(input logic rw, input logic [1:0] w,
                        input logic [12:0] a, input logic [15:0] dat,
                        input logic lsb);
      logic [15:0] ins;
      logic [15:0] q;
      int nbit;
      int k;
      ins = {rw, w, a};
      q = 16'h0000;
      nbit = 24 + 8 * int'(w);
      k = 0;
      csb = 1'b0;
      half(4);
      for (int b = 0; b < nbit; b++)
      begin
         sclk = 1'b0;
         // data bit position: msb order walks each byte downwards
         k = (b - 16) ^ (lsb ? 0 : 7);
         if (b < 16)
            sdio_q = lsb ? ins[b] : ins[15-b];
         else if (rw)
            sdio_q = ~sdio_q; // released line shows no stale level
         else
            sdio_q = dat[k];
         half(4);
         sclk = 1'b1;
         half(4);
         if (b >= 16)
            q[k] = sdio_w;
      end
      sclk = 1'b0;
      half(4);
      csb = 1'b1;
      sdio_q = ~sdio_q;
      rd_val = q;
      rd_stb = rw;
      half(1);
      rd_stb = 1'b0;
      half(4);
   endtask
endmodule

/* File: dv/adcsr_reg_bank_checker.sv */
// concurrent checks on the register bank pins and active configuration
module adcsr_reg_bank_checker #(
   parameter int N_REGS = 17
)(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // serial port pins
   input wire logic sclk,
   input wire logic csb,
   input wire logic sdio_i,
   input wire logic sdio_o,
   input wire logic sdio_oe,
   // active band
   input wire logic [2*N_REGS*8-1:0] active_cfg
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************************************
   // properties, all in the mclk domain
   // ****************************************************************
   localparam int B = N_REGS*8;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // first edge out of reset already shows the loaded defaults
   property p_rst_dflt;
      $rose(rst_n) |-> active_cfg[8 +: 8] == 8'h01
         && active_cfg[B+128 +: 8] == 8'hc0;
   endproperty
   a_rst_dflt: assert property (p_rst_dflt)
      else $error("active defaults wrong after reset");

   property p_rst_pin;
      $rose(rst_n) |-> !sdio_oe && !sdio_o;
   endproperty
   a_rst_pin: assert property (p_rst_pin)
      else $error("sdio driven after reset");

   // with the port idle nothing may reach the active band
   property p_idle_cfg;
      csb [*8] |-> $stable(active_cfg);
   endproperty
   a_idle_cfg: assert property (p_idle_cfg)
      else $error("active band moved while port idle");

   // a commit lands in one cycle, never staggered
   property p_one_shot;
      !$stable(active_cfg) |=> $stable(active_cfg);
   endproperty
   a_one_shot: assert property (p_one_shot)
      else $error("active band changed on two cycles in a row");

   property p_global;
      active_cfg[8 +: 8] == active_cfg[B+8 +: 8]
         && active_cfg[24 +: 8] == active_cfg[B+24 +: 8];
   endproperty
   a_global: assert property (p_global)
      else $error("global byte differs between channels");

   property p_oe_frame;
      $rose(sdio_oe) |-> !csb;
   endproperty
   a_oe_frame: assert property (p_oe_frame)
      else $error("sdio driven outside a frame");

   property p_oe_idle;
      csb [*5] |-> !sdio_oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("sdio still driven after deselect");

   // read data may only move in the low phase of the shift clock
   property p_hold;
      sclk [*3] |-> $stable(sdio_o);
   endproperty
   a_hold: assert property (p_hold)
      else $error("sdio moved while shift clock high");
endmodule

bind adcsr_reg_bank adcsr_reg_bank_checker #(.N_REGS(N_REGS)) u_chk (
   .mclk(mclk),
   .rst_n(rst_n),
   .sclk(sclk),
   .csb(csb),
   .sdio_i(sdio_i),
   .sdio_o(sdio_o),
   .sdio_oe(sdio_oe),
   .active_cfg(active_cfg)
);

/* File: rtl/adcsr_defines.svh */
// shared addresses, field masks, defaults and counts of the register bank
`ifndef ADCSR_DEFINES_SVH
`define ADCSR_DEFINES_SVH

// ****************************************************************
// register addresses (13-bit serial address space)
// ****************************************************************
`define ADCSR_ADDR_PORTCFG 13'h000
`define ADCSR_ADDR_PARTID 13'h001
`define ADCSR_ADDR_GRADE 13'h002
`define ADCSR_ADDR_CHSEL 13'h005
`define ADCSR_ADDR_XFER 13'h0ff
`define ADCSR_BAND_LO 13'h008
`define ADCSR_BAND_HI 13'h018

// ****************************************************************
// fields and defaults
// ****************************************************************
`define ADCSR_PORTCFG_DEF 8'h18
`define ADCSR_PORTCFG_LSB_MASK 8'h42
`define ADCSR_PORTCFG_SRST_MASK 8'h24
`define ADCSR_CHSEL_DEF 2'h3
`define ADCSR_CHSEL_ONLY_B 2'h2
`define ADCSR_CHSEL_BOTH 2'h3
`define ADCSR_XFER_CMD 8'h01
`define ADCSR_GRADE_LSB 4
`define ADCSR_DEF_IDX_CLK 5'h01
`define ADCSR_DEF_CLK 8'h01
`define ADCSR_DEF_IDX_VREF 5'h10
`define ADCSR_DEF_VREF 8'hc0

// ****************************************************************
// serial frame counts
// ****************************************************************
`define ADCSR_INSTR_LAST 4'hf
`define ADCSR_BYTE_LAST 4'h7
`define ADCSR_WLEN_STREAM 2'h3

`endif

/* File: rtl/adcsr_pkg.sv */
// types shared by the register bank modules
package adcsr_pkg;

   // frame phase of the serial port
   typedef enum logic [1:0]
   {
      PH_INSTR,
      PH_DATA,
      PH_DONE
   } adcsr_phase_e;

endpackage

/* File: rtl/adcsr_reg_bank.sv */
// serial-programmed configuration register bank with shadowed band
`include "adcsr_defines.svh"

// Operation
// RULE1 - host zeroes unassigned bits on writes
// RULE2 - host never writes fully unassigned addresses
// RULE3 - reset loads documented defaults before access
// RULE4 - band 0x08-0x18 writes hit holding copy
// RULE5 - writing 0x01 to 0xFF commits all holding
// RULE6 - transfer bit clears itself after update
// RULE7 - local registers per channel, picked by 0x05
// RULE8 - both select bits write both channels
// RULE9 - both bits set on read returns A
// RULE10 - global registers ignore channel select bits
// RULE11 - port config mirrored nibbles, default 0x18
// RULE12 - channel select B bit1, A bit0, 0x03
// RULE13 - MSB first by default, LSB bit switches
// RULE14 - soft reset restores defaults, self-clears
module adcsr_reg_bank #(
   parameter logic [7:0] PART_ID = 8'h5a, // arbitrary identity value
   parameter logic [1:0] GRADE = 2'h0,
   parameter int N_REGS = 17,
   parameter logic [16:0] LOCAL_MASK = 17'h00161
)(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // serial port pins
   input wire logic sclk,
   input wire logic csb,
   input wire logic sdio_i,
   output logic sdio_o,
   output logic sdio_oe,
   // active configuration of the shadowed band
   output logic [2*N_REGS*8-1:0] active_cfg
);

   localparam int IDX_W = 5;

   typedef struct packed {
      logic csb_s1, csb_s2;
      logic sclk_s1, sclk_s2, sclk_s3;
      logic sdio_s1, sdio_s2;
      adcsr_pkg::adcsr_phase_e ph;
      logic [3:0] bit_cnt;
      logic [15:0] sr;
      logic rw;
      logic [1:0] wlen;
      logic [1:0] byte_cnt;
      logic [12:0] addr;
      logic lsb_first;
      logic [1:0] chan_sel;
      logic xfer, rd_band;
      logic [7:0] rd_small, out_sr;
      logic sdio_o, sdio_oe;
   } adcsr_top_s;

   // ****************************************************************
   // address decoding helpers
   // ****************************************************************

   // true inside the shadowed band
   function automatic logic adcsr_in_band(input logic [12:0] a);
      return (a >= `ADCSR_BAND_LO) && (a <= `ADCSR_BAND_HI);
   endfunction

   // index of a band address into the bank
   function automatic logic [IDX_W-1:0] adcsr_idx(input logic [12:0] a);
      logic [12:0] off;
      off = a - `ADCSR_BAND_LO;
      return off[IDX_W-1:0];
   endfunction

   // local registers are duplicated per channel
   function automatic logic adcsr_is_local(input logic [12:0] a);
      return adcsr_in_band(a) && LOCAL_MASK[adcsr_idx(a)];
   endfunction

   // readback of the registers held outside the bank
   function automatic logic [7:0] adcsr_small_rd(input logic [12:0] a,
      input logic lsb, input logic [1:0] chs, input logic xf);
      logic [7:0] r;
      r = 8'h00;
      unique case (a)
         `ADCSR_ADDR_PORTCFG: r = `ADCSR_PORTCFG_DEF |
            (lsb ? `ADCSR_PORTCFG_LSB_MASK : 8'h00); // see RULE11
         `ADCSR_ADDR_PARTID: r = PART_ID;
         `ADCSR_ADDR_GRADE: r = 8'(GRADE) << `ADCSR_GRADE_LSB;
         `ADCSR_ADDR_CHSEL: r = {6'h00, chs};
         `ADCSR_ADDR_XFER: r = {7'h00, xf};
         default: r = 8'h00; // unsupported locations read zero
      endcase
      return r;
   endfunction

   localparam adcsr_top_s RST_VAL = '{
      csb_s1: 1'b1, csb_s2: 1'b1, ph: adcsr_pkg::PH_INSTR,
      lsb_first: 1'b0, // see RULE13
      chan_sel: `ADCSR_CHSEL_DEF, // see RULE12
      default: '0
   };

   adcsr_top_s q, d;
   logic rise, fall, rd_en, wr_en, rd_chan_b, xfer_p, clr;
   logic [15:0] nb;
   logic [7:0] byte_v, ld, wr_data, bank_rdata;
   logic [12:0] nxt_addr, rd_a;
   logic [IDX_W-1:0] wr_idx;
   logic [1:0] wr_mask;

   // ****************************************************************
   // serial frame engine and register writes
   // ****************************************************************

   // pins pass two flops; edges are found on the settled copies only
   always_comb
   begin
      d = q;
      rd_en = 1'b0;
      rd_a = '0;
      wr_en = 1'b0;
      wr_idx = '0;
      wr_mask = '0;
      wr_data = '0;
      rd_chan_b = 1'b0;
      xfer_p = 1'b0;
      clr = 1'b0;
      ld = '0;
      d.csb_s1 = csb;
      d.csb_s2 = q.csb_s1;
      d.sclk_s1 = sclk;
      d.sclk_s2 = q.sclk_s1;
      d.sclk_s3 = q.sclk_s2;
      d.sdio_s1 = sdio_i;
      d.sdio_s2 = q.sdio_s1;
      d.xfer = 1'b0; // see RULE6
      rise = q.sclk_s2 & ~q.sclk_s3;
      fall = ~q.sclk_s2 & q.sclk_s3;
      // shift direction follows the port config bit
      nb = q.lsb_first ? {q.sdio_s2, q.sr[15:1]}
                       : {q.sr[14:0], q.sdio_s2}; // see RULE13
      byte_v = q.lsb_first ? nb[15:8] : nb[7:0];
      nxt_addr = q.lsb_first ? q.addr + 13'h0001 : q.addr - 13'h0001;
      if (q.csb_s2)
      begin
         d.ph = adcsr_pkg::PH_INSTR;
         d.bit_cnt = '0;
         d.sdio_oe = 1'b0;
      end
      else if (rise)
      begin
         d.sr = nb;
         d.bit_cnt = q.bit_cnt + 4'h1;
         unique case (q.ph)
            adcsr_pkg::PH_INSTR:
            begin
               if (q.bit_cnt == `ADCSR_INSTR_LAST)
               begin
                  d.rw = nb[15];
                  d.wlen = nb[14:13];
                  d.addr = nb[12:0];
                  d.ph = adcsr_pkg::PH_DATA;
                  d.bit_cnt = '0;
                  d.byte_cnt = '0;
                  rd_en = nb[15];
                  rd_a = nb[12:0];
               end
            end
            adcsr_pkg::PH_DATA:
            begin
               if (q.bit_cnt == `ADCSR_BYTE_LAST)
               begin
                  d.bit_cnt = '0;
                  d.addr = nxt_addr;
                  d.byte_cnt = q.byte_cnt + 2'h1;
                  if (!q.rw && adcsr_in_band(q.addr))
                  begin
                     wr_en = 1'b1;
                     wr_idx = adcsr_idx(q.addr);
                     wr_data = byte_v;
                     // globals ignore the select bits
                     wr_mask = adcsr_is_local(q.addr) ? q.chan_sel
                               : `ADCSR_CHSEL_BOTH; // see RULE7 see RULE10
                  end
                  else if (!q.rw)
                  begin
                     unique case (q.addr)
                        `ADCSR_ADDR_PORTCFG:
                        begin
                           if ((byte_v & `ADCSR_PORTCFG_SRST_MASK) != 8'h00)
                           begin
                              // bit is never stored, so it reads back zero
                              clr = 1'b1; // see RULE14
                              d.lsb_first = 1'b0;
                              d.chan_sel = `ADCSR_CHSEL_DEF;
                           end
                           else
                           begin
                              d.lsb_first = |(byte_v &
                                 `ADCSR_PORTCFG_LSB_MASK); // see RULE11
                           end
                        end
                        `ADCSR_ADDR_CHSEL: d.chan_sel = byte_v[1:0];
                        `ADCSR_ADDR_XFER:
                        begin
                           if (byte_v == `ADCSR_XFER_CMD)
                           begin
                              xfer_p = 1'b1; // see RULE5
                              d.xfer = 1'b1;
                           end
                        end
                        default: ; // read-only or unsupported: ignored
                     endcase
                  end
                  if (q.wlen != `ADCSR_WLEN_STREAM && q.byte_cnt == q.wlen)
                  begin
                     d.ph = adcsr_pkg::PH_DONE;
                  end
                  else
                  begin
                     rd_en = q.rw;
                     rd_a = nxt_addr;
                  end
               end
            end
            adcsr_pkg::PH_DONE: ; // extra clocks until csb rises
         endcase
      end
      else if (fall)
      begin
         // read data changes on the falling edge, held over the rise
         if (q.ph == adcsr_pkg::PH_DATA && q.rw)
         begin
            d.sdio_oe = 1'b1;
            if (q.bit_cnt == 4'h0)
            begin
               ld = q.rd_band ? bank_rdata : q.rd_small;
               d.sdio_o = q.lsb_first ? ld[0] : ld[7];
               d.out_sr = q.lsb_first ? {1'b0, ld[7:1]} : {ld[6:0], 1'b0};
            end
            else
            begin
               d.sdio_o = q.lsb_first ? q.out_sr[0] : q.out_sr[7];
               d.out_sr = q.lsb_first ? {1'b0, q.out_sr[7:1]}
                                      : {q.out_sr[6:0], 1'b0};
            end
         end
         else
         begin
            d.sdio_oe = 1'b0;
         end
      end
      // read fetch: both copies set returns channel a
      if (rd_en)
      begin
         d.rd_band = adcsr_in_band(rd_a);
         d.rd_small = adcsr_small_rd(rd_a, d.lsb_first, d.chan_sel, q.xfer);
         rd_chan_b = adcsr_is_local(rd_a) &&
                     q.chan_sel == `ADCSR_CHSEL_ONLY_B; // see RULE9
      end
   end

   // single register stage for all top-level state
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         q <= RST_VAL; // see RULE3
      end
      else
      begin
         q <= d;
      end
   end

   // ****************************************************************
   // shadowed band storage
   // ****************************************************************

   adcsr_shadow_bank #(.N_REGS(N_REGS), .IDX_W(IDX_W)) u_bank (
      .mclk(mclk),
      .rst_n(rst_n),
      .clr(clr),
      .wr_en(wr_en),
      .wr_idx(wr_idx),
      .wr_data(wr_data),
      .wr_mask(wr_mask),
      .xfer(xfer_p),
      .rd_en(rd_en),
      .rd_idx(adcsr_idx(rd_a)),
      .rd_chan_b(rd_chan_b),
      .rd_data(bank_rdata),
      .active_cfg(active_cfg)
   );

   assign sdio_o = q.sdio_o;
   assign sdio_oe = q.sdio_oe;

endmodule

/* File: rtl/adcsr_shadow_bank.sv */
// holding and active copies of the shadowed band, one set per channel
`include "adcsr_defines.svh"

module adcsr_shadow_bank #(
   parameter int N_REGS = 17,
   parameter int IDX_W = 5
)(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clr,
   // host write into the holding copies
   input wire logic wr_en,
   input wire logic [IDX_W-1:0] wr_idx,
   input wire logic [7:0] wr_data,
   input wire logic [1:0] wr_mask,
   // commit of holding into active
   input wire logic xfer,
   // registered readback of the holding copy
   input wire logic rd_en,
   input wire logic [IDX_W-1:0] rd_idx,
   input wire logic rd_chan_b,
   output logic [7:0] rd_data,
   // active configuration, channel b in the upper half
   output logic [2*N_REGS*8-1:0] active_cfg
);

   typedef struct packed {
      logic [1:0][N_REGS-1:0][7:0] hold;
      logic [1:0][N_REGS-1:0][7:0] act;
      logic [7:0] rdata;
   } adcsr_bank_s;

   // default image, used at reset and by soft reset
   function automatic adcsr_bank_s adcsr_defaults();
      adcsr_bank_s v;
      v = '0;
      for (int ch = 0; ch < 2; ch++)
      begin
         v.hold[ch][`ADCSR_DEF_IDX_CLK] = `ADCSR_DEF_CLK;
         v.hold[ch][`ADCSR_DEF_IDX_VREF] = `ADCSR_DEF_VREF;
      end
      v.act = v.hold;
      return v;
   endfunction

   localparam adcsr_bank_s RST_VAL = adcsr_defaults();

   adcsr_bank_s q, d;

   // writes land only in the holding copy; active moves as one block
   always_comb
   begin
      d = q;
      if (clr)
      begin
         d = RST_VAL; // see RULE14
      end
      else
      begin
         for (int ch = 0; ch < 2; ch++)
         begin
            if (wr_en && wr_mask[ch])
            begin
               d.hold[ch][wr_idx] = wr_data; // see RULE4 see RULE8
            end
         end
         if (xfer)
         begin
            d.act = q.hold; // see RULE5
         end
         if (rd_en)
         begin
            d.rdata = q.hold[rd_chan_b][rd_idx];
         end
      end
   end

   // single register stage for all bank state
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         q <= RST_VAL; // see RULE3
      end
      else
      begin
         q <= d;
      end
   end

   assign rd_data = q.rdata;
   assign active_cfg = q.act;

endmodule
